/* logic/acps_top.sv */
// How it works
// - channel code 0..5 connects analog input 0..5 to the converter
// - reset clears the channel register to 00h, input 0
// - channel register takes single-bit and whole-byte writes
// - each channel register write inserts one wait cycle
// - config code k (bits 2:0) makes the k lowest pins digital, others analog
// - reset loads config register with 08h, all pins analog
// - each config register write inserts one wait cycle
// - segment selection forces segment output regardless of config
// - direction bit 0 enables output buffer of a non-segment pin, 1 disables it
// - reset sets direction register to ffh, all inputs
// - analog pin in output mode never acts as analog input
// - analog input pin is converted only when channel code selects it
// - digital pin is input in input mode, output in output mode
// - config and direction registers take single-bit and byte writes
`timescale 1ns/1ps
`include "acps_params.svh"

module acps_top
   import acps_pkg::*;
(
   // clock and reset
   input  wire logic                         ref_clk_i,
   input  wire logic                         rst_n_i,
   // cpu memory access
   input  wire logic [15:0]                  cpu_addr_i,
   input  wire logic                         cpu_wr_i,
   input  wire logic                         cpu_bit_wr_i,
   input  wire logic [2:0]                   cpu_bit_idx_i,
   input  wire logic [7:0]                   cpu_wdata_i,
   input  wire logic                         cpu_rd_i,
   output logic      [7:0]                   cpu_rdata_o,
   output logic                              cpu_wait_o,
   // pin side
   input  wire logic [`ACPS_NUM_PINS-1:0]    seg_fn_sel_i,
   input  wire logic [`ACPS_NUM_PINS-1:0]    port_latch_i,
   output logic      [`ACPS_NUM_PINS-1:0]    pin_oe_o,
   output logic      [`ACPS_NUM_PINS-1:0]    pin_do_o,
   output logic      [`ACPS_NUM_PINS-1:0]    pin_analog_o,
   output logic      [`ACPS_NUM_PINS-1:0]    pin_segment_o,
   output logic      [`ACPS_NUM_PINS-1:0]    conv_sel_o
);

   ////////////////////////////////////////////////////////////////////////////
   // reset release

   logic rst_s1_q;
   logic rst_s2_q;
   logic rst_n;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   assign rst_n = rst_s2_q;

   ////////////////////////////////////////////////////////////////////////////
   // register file

   function automatic logic [7:0] merge_wr(input logic [7:0] cur,
                                           input logic       bit_wr,
                                           input logic [2:0] idx,
                                           input logic [7:0] wdata);
      logic [7:0] res;
      res = cur;
      if (bit_wr) begin
         res[idx] = wdata[0];
      end else begin
         res = wdata;
      end
      return res;
   endfunction

   logic [7:0] chsel_q, chsel_d;
   logic [7:0] cfg_q,   cfg_d;
   logic [7:0] dir_q,   dir_d;
   logic [7:0] rdata_q, rdata_d;
   logic       wait_q,  wait_d;
   logic       hit_ch;
   logic       hit_cfg;
   logic       hit_dir;
   logic       do_wr;

   always_comb begin
      do_wr   = cpu_wr_i || cpu_bit_wr_i;
      hit_ch  = (cpu_addr_i == `ACPS_ADDR_CHSEL);
      hit_cfg = (cpu_addr_i == `ACPS_ADDR_CFG);
      hit_dir = (cpu_addr_i == `ACPS_ADDR_DIR);
      chsel_d = chsel_q;
      cfg_d   = cfg_q;
      dir_d   = dir_q;
      if (do_wr && hit_ch) begin
         // upper bits are not stored, so they always read zero
         chsel_d = merge_wr(chsel_q, cpu_bit_wr_i, cpu_bit_idx_i, cpu_wdata_i)
                   & `ACPS_CHSEL_MASK;
      end
      if (do_wr && hit_cfg) begin
         cfg_d = merge_wr(cfg_q, cpu_bit_wr_i, cpu_bit_idx_i, cpu_wdata_i);
      end
      if (do_wr && hit_dir) begin
         dir_d = merge_wr(dir_q, cpu_bit_wr_i, cpu_bit_idx_i, cpu_wdata_i);
      end
      // one wait cycle follows any write that lands on these registers
      wait_d = do_wr && (hit_ch || hit_cfg || hit_dir);
      rdata_d = rdata_q;
      if (cpu_rd_i) begin
         if (hit_ch) begin
            rdata_d = chsel_q;
         end else if (hit_cfg) begin
            rdata_d = cfg_q;
         end else if (hit_dir) begin
            rdata_d = dir_q;
         end else begin
            rdata_d = 8'h00;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         chsel_q <= `ACPS_RST_CHSEL;
         cfg_q   <= `ACPS_RST_CFG;
         dir_q   <= `ACPS_RST_DIR;
         rdata_q <= 8'h00;
         wait_q  <= 1'b0;
      end else begin
         chsel_q <= chsel_d;
         cfg_q   <= cfg_d;
         dir_q   <= dir_d;
         rdata_q <= rdata_d;
         wait_q  <= wait_d;
      end
   end

   assign cpu_rdata_o = rdata_q;
   assign cpu_wait_o  = wait_q;

   ////////////////////////////////////////////////////////////////////////////
   // per-pin function, registered onto the outputs
   // outputs lag settings by one cycle; cheap and glitch free at the pads

   logic [`ACPS_NUM_PINS-1:0] oe_d, do_d, ana_d, seg_d, conv_d;
   logic [`ACPS_NUM_PINS-1:0] oe_q, do_q, ana_q, seg_q, conv_q;

   genvar gi;
   generate
      for (gi = 0; gi < `ACPS_NUM_PINS; gi++) begin : g_pin
         acps_fn_t fn;
         acps_pin_fn #(
            .PIN (3'(gi))
         ) u_fn (
            .seg_sel_i  (seg_fn_sel_i[gi]),
            .dir_in_i   (dir_q[gi]),
            .cfg_code_i (cfg_q[`ACPS_FIELD_MSB:0]),
            .ch_code_i  (chsel_q[`ACPS_FIELD_MSB:0]),
            .fn_o       (fn),
            .oe_o       (oe_d[gi]),
            .conv_o     (conv_d[gi])
         );
         assign ana_d[gi] = (fn == ACPS_FN_ANALOG);
         assign seg_d[gi] = (fn == ACPS_FN_SEGMENT);
         assign do_d[gi]  = port_latch_i[gi];
      end
   endgenerate

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         oe_q   <= '0;
         do_q   <= '0;
         ana_q  <= '0;
         seg_q  <= '0;
         conv_q <= '0;
      end else begin
         oe_q   <= oe_d;
         do_q   <= do_d;
         ana_q  <= ana_d;
         seg_q  <= seg_d;
         conv_q <= conv_d;
      end
   end

   assign pin_oe_o      = oe_q;
   assign pin_do_o      = do_q;
   assign pin_analog_o  = ana_q;
   assign pin_segment_o = seg_q;
   assign conv_sel_o    = conv_q;

endmodule

/* logic/acps_params.svh */
`ifndef ACPS_PARAMS_SVH
`define ACPS_PARAMS_SVH

// register addresses on the cpu data space
`define ACPS_ADDR_CFG     16'hff8f
`define ACPS_ADDR_CHSEL   16'hff29
`define ACPS_ADDR_DIR     16'hff22

// reset values
`define ACPS_RST_CFG      8'h08
`define ACPS_RST_CHSEL    8'h00
`define ACPS_RST_DIR      8'hff

// field layout
`define ACPS_FIELD_MSB    2
`define ACPS_NUM_PINS     6
`define ACPS_LAST_CODE    3'h5

// mask of the channel bits that hold state; the rest read as zero
`define ACPS_CHSEL_MASK   8'h07

`endif

/* logic/acps_pkg.sv */
`include "acps_params.svh"

package acps_pkg;

   typedef enum logic [1:0] {
      ACPS_FN_ANALOG,
      ACPS_FN_DIGITAL,
      ACPS_FN_SEGMENT
   } acps_fn_t;

   typedef logic [`ACPS_FIELD_MSB:0] acps_code_t;

endpackage

/* logic/acps_pin_fn.sv */
`timescale 1ns/1ps
`include "acps_params.svh"

module acps_pin_fn
   import acps_pkg::*;
#(
   parameter logic [2:0] PIN = 3'h0
) (
   // settings
   input  wire logic       seg_sel_i,
   input  wire logic       dir_in_i,
   input  wire acps_code_t cfg_code_i,
   input  wire acps_code_t ch_code_i,
   // decoded function
   output acps_fn_t        fn_o,
   output logic            oe_o,
   output logic            conv_o
);

   logic cfg_ok;
   logic is_dig;

   always_comb begin
      cfg_ok = (cfg_code_i <= `ACPS_LAST_CODE);
      // prohibited cfg codes fall back to all-digital, the safe state
      is_dig = !cfg_ok || (PIN < cfg_code_i);
      // analog with output mode is refused; the pin stays digital output
      if (seg_sel_i) begin
         fn_o = ACPS_FN_SEGMENT;
      end else if (is_dig || !dir_in_i) begin
         fn_o = ACPS_FN_DIGITAL;
      end else begin
         fn_o = ACPS_FN_ANALOG;
      end
      oe_o   = (fn_o == ACPS_FN_DIGITAL) && !dir_in_i;
      conv_o = (fn_o == ACPS_FN_ANALOG) && (ch_code_i == PIN)
               && (ch_code_i <= `ACPS_LAST_CODE);
   end

endmodule

/* verification/acps_monitor.sv */
`timescale 1ns/1ps
`include "acps_params.svh"
module acps_monitor
   import acps_pkg::*;
(
   // clock and reset
   input wire logic        ref_clk_i,
   input wire logic        rst_n_i,
   // cpu side
   input wire logic [15:0] cpu_addr_i,
   input wire logic        cpu_wr_i,
   input wire logic        cpu_bit_wr_i,
   input wire logic        cpu_wait_o,
   // pin side
   input wire logic [5:0]  seg_fn_sel_i,
   input wire logic [5:0]  port_latch_i,
   input wire logic [5:0]  pin_oe_o,
   input wire logic [5:0]  pin_do_o,
   input wire logic [5:0]  pin_analog_o,
   input wire logic [5:0]  pin_segment_o,
   input wire logic [5:0]  conv_sel_o
);
   ////////////////////////////////////////////////////////////////
   // settle counter: reset release passes two sync flops first
   logic [1:0] up_q;
   logic [1:0] up_d;
   logic       ok;
   logic       wr_hit;
   assign ok = up_q == 2'h3;
   assign wr_hit = (cpu_wr_i || cpu_bit_wr_i) && (cpu_addr_i == `ACPS_ADDR_CFG
                   || cpu_addr_i == `ACPS_ADDR_CHSEL || cpu_addr_i == `ACPS_ADDR_DIR);
   always_comb begin
      up_d = ok ? up_q : up_q + 2'h1;
   end
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         up_q <= 2'h0;
      end else begin
         up_q <= up_d;
      end
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   wr_wait_a: assert property (wr_hit |=> cpu_wait_o)
      else $error("write gave no wait cycle");
   wait_cause_a: assert property (cpu_wait_o |-> $past(wr_hit))
      else $error("wait cycle without a register write");
   seg_follow_a: assert property (ok |-> pin_segment_o == $past(seg_fn_sel_i))
      else $error("segment output does not follow selection");
   seg_only_a: assert property ((pin_segment_o
                                 & (pin_analog_o | pin_oe_o | conv_sel_o)) == 6'h0)
      else $error("segment pin also has another function");
   latch_copy_a: assert property (ok |-> pin_do_o == $past(port_latch_i))
      else $error("pin data is not the latch value");
   one_conv_a: assert property ($onehot0(conv_sel_o))
      else $error("more than one converter input");
   conv_analog_a: assert property ((conv_sel_o & ~pin_analog_o) == 6'h0)
      else $error("converter takes a non analog pin");
   analog_oe_a: assert property ((pin_analog_o & pin_oe_o) == 6'h0)
      else $error("analog pin drives its buffer");
endmodule
bind acps_top acps_monitor u_mon (.ref_clk_i, .rst_n_i, .cpu_addr_i, .cpu_wr_i, .cpu_bit_wr_i,
   .cpu_wait_o, .seg_fn_sel_i, .port_latch_i, .pin_oe_o, .pin_do_o, .pin_analog_o,
   .pin_segment_o, .conv_sel_o);

/* verification/acps_pad_model.sv */
`timescale 1ns/1ps
module acps_pad_model (
   input  wire logic       ref_clk_i,
   input  wire logic [5:0] oe_i,
   input  wire logic [5:0] do_i,
   output logic      [5:0] pad_o
);
   initial pad_o = 6'h00;
   // an undriven pad toggles so a stale level never looks valid
   // plain always: the initial value above is a second writer of pad_o
   always @(posedge ref_clk_i) begin
      pad_o <= (oe_i & do_i) | (~oe_i & ~pad_o);
   end
endmodule

/* verification/adc_channel_pin_select_tb.sv */
`timescale 1ns/1ps
`include "acps_params.svh"
module adc_channel_pin_select_tb;
   import acps_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, bw = 1'b0, rd = 1'b0, wt;
   logic [15:0] ad = 16'h0000;
   logic [2:0]  bi = 3'h0;
   logic [7:0]  wd = 8'h00, rdat, m_cfg = 8'h08, m_ch = 8'h00, m_dir = 8'hff;
   logic [5:0]  seg = 6'h00, lat = 6'h00, oe, dout, ana, sgo, cv, pad;
   logic [15:0] adr [0:2] = '{`ACPS_ADDR_CFG, `ACPS_ADDR_CHSEL, `ACPS_ADDR_DIR};
   logic [31:0] r = 32'h67019e75;
   int          errors = 0, checks_done = 0, i, k;
   // the clock never stops, so no register write meets a stopped peripheral clock
   always #20 clk = ~clk;
   acps_top u_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .cpu_addr_i(ad), .cpu_wr_i(wr),
      .cpu_bit_wr_i(bw), .cpu_bit_idx_i(bi), .cpu_wdata_i(wd), .cpu_rd_i(rd),
      .cpu_rdata_o(rdat), .cpu_wait_o(wt), .seg_fn_sel_i(seg), .port_latch_i(lat),
      .pin_oe_o(oe), .pin_do_o(dout), .pin_analog_o(ana), .pin_segment_o(sgo),
      .conv_sel_o(cv));
   acps_pad_model u_pad (.ref_clk_i(clk), .oe_i(oe), .do_i(dout), .pad_o(pad));
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] mg(input logic [7:0] o, d, input logic b, input logic [2:0] x);
      mg = b ? o : d;
      if (b) mg[x] = d[0];
   endfunction
   function automatic logic [23:0] ex(input logic [5:0] sg);
      logic [5:0] a, o, v;
      a = 6'h00;
      o = 6'h00;
      v = 6'h00;
      for (int p = 0; p < 6; p++) begin
         if (sg[p]) continue;
         if (m_cfg[2:0] <= p && m_dir[p]) begin
            a[p] = 1'b1;
            v[p] = m_ch[2:0] == p;
         end else o[p] = !m_dir[p];
      end
      return {sg, a, o, v};
   endfunction
   task chk(input logic [23:0] g, e);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask
   ////////////////////////////////////////////////////////////////
   task wr8(input logic [15:0] a, input logic [7:0] d, input logic b, input logic [2:0] x);
      @(posedge clk);
      ad <= a; wd <= d; bi <= x; wr <= !b; bw <= b;
      @(posedge clk);
      wr <= 1'b0; bw <= 1'b0;
      #1;
      if (a == adr[0]) m_cfg = mg(m_cfg, d, b, x);
      if (a == adr[1]) m_ch = mg(m_ch, d, b, x) & `ACPS_CHSEL_MASK;
      if (a == adr[2]) m_dir = mg(m_dir, d, b, x);
      chk(wt, a == adr[0] || a == adr[1] || a == adr[2]);
   endtask
   task rdc(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      ad <= a; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdat, e);
   endtask
   task rall();
      rdc(adr[0], m_cfg);
      rdc(adr[1], m_ch);
      rdc(adr[2], m_dir);
   endtask
   task pins();
      repeat (3) @(posedge clk);
      #1;
      chk({sgo, ana, oe, cv}, ex(seg));
      chk({dout, pad & oe}, {lat, lat & oe});
   endtask
   task stop_test();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      pins();
      rall();
      $display("reset test done");
      // software keeps channel bits 7:3 at zero and writes the same code 0..7 to config and channel
      for (k = 0; k < 8; k++) begin
         wr8(adr[0], 8'(k), 1'b0, 3'h0);
         wr8(adr[1], 8'(k), 1'b0, 3'h0);
         pins();
      end
      wr8(16'hff30, 8'h5a, 1'b0, 3'h0);
      rdc(16'hff30, 8'h00);
      $display("code test done");
      for (i = 0; i < 200; i++) begin
         r = nx(r);
         k = r[9:8] % 3;
         @(posedge clk);
         seg <= r[15:10] & {6{r[16]}};
         lat <= r[22:17];
         wr8(adr[k], k == 1 ? r[7:0] & 8'h07 : r[7:0], r[23],
             k == 1 ? r[25:24] % 3 : r[26:24]);
         pins();
         if (r[27]) rall();
      end
      $display("random test done");
      // a second reset in mid-run must bring back every reset value
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      m_cfg = `ACPS_RST_CFG;
      m_ch  = `ACPS_RST_CHSEL;
      m_dir = `ACPS_RST_DIR;
      repeat (2) @(posedge clk);
      pins();
      rall();
      $display("mid-run reset test done");
      stop_test();
   end
endmodule
